/* sss_slave.sv */
// slave end: serial shift logic with slave-select resync and a wishbone register file
//
// Overview of operation
// R1: shift only on external clock; flag last bit
// R2: master idles clock before enable
// R3: polarity bit sets idle; clock level readable
// R4: runs during sleep; byte wakes if enabled
// R5: second byte group echoes first received
// R6: overwrite enable accepts buffer writes unread
// R7: select falling starts a new transmission
// R8: select high resets shift logic
// R9: select sync only in mode 0100
// R10: select low enables shifting, drives output
// R11: select high floats output immediately; the code drops the output enable three clock cycles after the select pin rises
// R12: counter cleared by select high or disable
// R13: edge select needs select control enabled
// R14: sample phase kept clear as slave
// R15: byte moves to buffer, next loaded
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module sss_slave
	import sss_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	input  wire logic        sleep_i,
	output logic             wake_o,
	sss_link_if.slave        link
);
	logic [8:0]         ctrl_q;
	logic [1:0]         sck_s_q;
	logic [1:0]         ss_s_q;
	logic [1:0]         mosi_s_q;
	logic               act_prev_q;
	logic [7:0]         sr_q;
	logic [2:0]         cnt_q;
	logic [7:0]         rx_buf_q;
	logic               rx_full_q;
	logic [7:0]         tx_buf_q;
	logic               tx_pend_q;
	logic               sdo_q;
	logic               sdo_oe_q;
	logic [SSS_IRQ_W-1:0] irq_stat_q;
	logic [SSS_IRQ_W-1:0] irq_mask_q;
	logic               ack_q;
	logic [31:0]        rdat_q;
	logic               irq_q;
	logic               wake_q;
	logic [3:0]         mode;
	logic               enabled;
	logic               ss_ctl;
	logic               ss_hi;
	logic               act;
	logic               lead_edge;
	logic               trail_edge;
	logic               smp_edge;
	logic               lau_edge;
	logic               run;
	logic               byte_done;
	logic [7:0]         rx_byte;
	logic               acc;
	logic               wr;
	logic               rd;
	logic               wr_data;
	logic               rd_data;
	logic               wr_refused;
	logic               ovf;
	logic [SSS_IRQ_W-1:0] irq_set;

	assign mode       = ctrl_q[SSS_CTRL_MODE_LSB +: 4];
	assign enabled    = ctrl_q[SSS_CTRL_EN] && (mode == SSS_MODE_SLAVE_SS || mode == SSS_MODE_SLAVE_NOSS);
	assign ss_ctl     = (mode == SSS_MODE_SLAVE_SS); // R9
	assign ss_hi      = ss_s_q[1];
	// clock level relative to the idle level chosen by polarity
	assign act        = sck_s_q[1] ^ ctrl_q[SSS_CTRL_CPOL]; // R3
	assign lead_edge  = act && !act_prev_q;
	assign trail_edge = !act && act_prev_q;
	// edge select: sample on leading when set, otherwise on trailing
	assign smp_edge   = ctrl_q[SSS_CTRL_CKE] ? lead_edge : trail_edge;
	assign lau_edge   = ctrl_q[SSS_CTRL_CKE] ? trail_edge : lead_edge;
	assign run        = enabled && !(ss_ctl && ss_hi); // R7 R10
	assign byte_done  = run && smp_edge && (cnt_q == SSS_LAST_BIT); // R1
	assign rx_byte    = {sr_q[6:0], mosi_s_q[1]};

	assign acc        = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr         = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
	assign rd         = acc && !wb_we_i;
	assign wr_data    = wr && (wb_adr_i == SSS_DATA_OFS);
	assign rd_data    = rd && (wb_adr_i == SSS_DATA_OFS);
	assign wr_refused = wr_data && rx_full_q && !ctrl_q[SSS_CTRL_BUFFER_OVERWRITE_EN]; // R6
	assign ovf        = byte_done && rx_full_q && !rd_data && !ctrl_q[SSS_CTRL_BUFFER_OVERWRITE_EN];
	assign irq_set    = {wr_refused, ovf, byte_done};

	// pin synchronisers; stage 0 feeds stage 1 only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sck_s_q    <= 2'h0;
			ss_s_q     <= 2'h3;
			mosi_s_q   <= 2'h0;
			act_prev_q <= 1'b0;
		end else begin
			sck_s_q    <= {sck_s_q[0], link.sck};
			ss_s_q     <= {ss_s_q[0], link.ss_n};
			mosi_s_q   <= {mosi_s_q[0], link.mosi};
			act_prev_q <= act;
		end
	end

	// bit counter and shift register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 3'h0;
			sr_q  <= SSS_DATA_RST;
		end else if (!run) begin
			cnt_q <= 3'h0; // R8 R12
			if (tx_pend_q) begin
				sr_q <= tx_buf_q;
			end
		end else if (smp_edge) begin
			cnt_q <= cnt_q + 3'h1; // R1 R4
			if (byte_done && tx_pend_q) begin
				sr_q <= tx_buf_q; // R15
			end else begin
				sr_q <= rx_byte; // R5
			end
		end
	end

	// serial data output and its enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sdo_q    <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			sdo_oe_q <= run; // R10 R11
			if (!run || lau_edge || cnt_q == 3'h0) begin
				sdo_q <= sr_q[7];
			end
		end
	end

	// receive buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buf_q  <= SSS_DATA_RST;
			rx_full_q <= 1'b0;
		end else if (byte_done && !ovf) begin
			rx_buf_q  <= rx_byte; // R15
			rx_full_q <= 1'b1;
		end else if (rd_data) begin
			rx_full_q <= 1'b0;
		end
	end

	// transmit buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_buf_q  <= SSS_DATA_RST;
			tx_pend_q <= 1'b0;
		end else if (wr_data && !wr_refused) begin
			tx_buf_q  <= wb_dat_i[7:0]; // R6
			tx_pend_q <= 1'b1;
		end else if ((byte_done || !run) && tx_pend_q) begin
			tx_pend_q <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= SSS_CTRL_RST;
		end else if (wr && wb_adr_i == SSS_CTRL_OFS) begin
			ctrl_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1]) begin
				ctrl_q[8] <= wb_dat_i[8];
			end
		end
	end

	// sticky event flags, set wins over write-one clear, and mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end else begin
			if (wr && wb_adr_i == SSS_IRQ_STAT_OFS) begin
				irq_stat_q <= (irq_stat_q & ~wb_dat_i[SSS_IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set; // R1
			end
			if (wr && wb_adr_i == SSS_IRQ_MASK_OFS) begin
				irq_mask_q <= wb_dat_i[SSS_IRQ_W-1:0];
			end
		end
	end

	// interrupt and wake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q  <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			irq_q  <= |(irq_stat_q & irq_mask_q);
			wake_q <= sleep_i && irq_stat_q[SSS_IRQ_DONE] && irq_mask_q[SSS_IRQ_DONE]; // R4
		end
	end

	// bus answer: one wait state, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= acc;
			if (rd) begin
				case (wb_adr_i)
					SSS_CTRL_OFS:     rdat_q <= {23'h0, ctrl_q};
					SSS_STATUS_OFS:   rdat_q <= {29'h0, ss_hi, sck_s_q[1], rx_full_q}; // R3
					SSS_DATA_OFS:     rdat_q <= {24'h0, rx_buf_q};
					SSS_IRQ_STAT_OFS: rdat_q <= {29'h0, irq_stat_q};
					SSS_IRQ_MASK_OFS: rdat_q <= {29'h0, irq_mask_q};
					default:          rdat_q <= 32'h0000_0000;
				endcase
			end else begin
				rdat_q <= 32'h0000_0000;
			end
		end
	end

	assign wb_ack_o     = ack_q;
	assign wb_dat_o     = rdat_q;
	assign irq_o        = irq_q;
	assign wake_o       = wake_q;
	assign link.miso    = sdo_q;
	assign link.miso_oe = sdo_oe_q;
endmodule : sss_slave

/* sss_pkg.sv */
// shared constants for the slave-select synchronised serial port and its master
package sss_pkg;
	localparam logic [7:0] SSS_CTRL_OFS     = 8'h00;
	localparam logic [7:0] SSS_STATUS_OFS   = 8'h04;
	localparam logic [7:0] SSS_DATA_OFS     = 8'h08;
	localparam logic [7:0] SSS_IRQ_STAT_OFS = 8'h0C;
	localparam logic [7:0] SSS_IRQ_MASK_OFS = 8'h10;
	localparam int         SSS_CTRL_MODE_LSB = 0;
	localparam int         SSS_CTRL_CPOL     = 4;
	localparam int         SSS_CTRL_CKE      = 5;
	localparam int         SSS_CTRL_SMP      = 6;
	localparam int         SSS_CTRL_EN       = 7;
	localparam int         SSS_CTRL_BUFFER_OVERWRITE_EN     = 8;
	localparam int         SSS_ST_RXFULL     = 0;
	localparam int         SSS_ST_SCK        = 1;
	localparam int         SSS_ST_SS         = 2;
	localparam int         SSS_IRQ_DONE      = 0;
	localparam int         SSS_IRQ_OVF       = 1;
	localparam int         SSS_IRQ_WREF      = 2;
	localparam int         SSS_IRQ_W         = 3;
	localparam logic [3:0] SSS_MODE_SLAVE_SS   = 4'h4;
	localparam logic [3:0] SSS_MODE_SLAVE_NOSS = 4'h5;
	localparam logic [8:0] SSS_CTRL_RST      = 9'h000;
	localparam logic [7:0] SSS_DATA_RST      = 8'h00;
	localparam logic [2:0] SSS_LAST_BIT      = 3'h7;
	localparam int         SSS_LINK_HALF_NS  = 80;
	localparam int         SSS_CLK_NS        = 10;
	localparam int         SSS_LINK_HALF_CYC = (SSS_LINK_HALF_NS + SSS_CLK_NS - 1) / SSS_CLK_NS;
	typedef enum logic [3:0] {
		SSS_M_IDLE  = 4'b0001,
		SSS_M_SETUP = 4'b0010,
		SSS_M_RUN   = 4'b0100,
		SSS_M_GAP   = 4'b1000
	} sss_mstate_t;
endpackage : sss_pkg

/* sss_link_if.sv */
// serial link wires between the master end and the slave end
`timescale 1ns/1ns
interface sss_link_if;
	logic sck;
	logic ss_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	modport master (output sck, output ss_n, output mosi, input miso, input miso_oe);
	modport slave  (input sck, input ss_n, input mosi, output miso, output miso_oe);
endinterface : sss_link_if

/* sss_master.sv */
// master end: makes the shift clock and slave select, one byte per start
`timescale 1ns/1ns
module sss_master
	import sss_pkg::*;
#(
	parameter int HALF_CYC = 8
)(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cpol_i,
	input  wire logic       cke_i,
	input  wire logic       start_i,
	input  wire logic       last_i,
	input  wire logic [7:0] tx_i,
	output logic            busy_o,
	output logic            done_o,
	output logic      [7:0] rx_o,
	sss_link_if.master      link
);
	sss_mstate_t  st_q;
	logic [7:0]   div_q;
	logic [4:0]   tr_q;
	logic [7:0]   sr_q;
	logic         last_q;
	logic         sck_q;
	logic         ss_n_q;
	logic         mosi_q;
	logic [1:0]   miso_s_q;
	logic         busy_q;
	logic         done_q;
	logic [7:0]   rx_q;
	logic         tick;
	logic         lead;
	logic         input_sample_phase;

	assign tick = (div_q == 8'(HALF_CYC - 1));
	assign lead = !tr_q[0];
	assign input_sample_phase  = cke_i ? lead : !lead;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			miso_s_q <= 2'h0;
		end else begin
			// released data line reads as pulled high
			miso_s_q <= {miso_s_q[0], link.miso_oe ? link.miso : 1'b1};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q   <= SSS_M_IDLE;
			div_q  <= 8'h00;
			tr_q   <= 5'h00;
			sr_q   <= 8'h00;
			last_q <= 1'b1;
			sck_q  <= 1'b0;
			ss_n_q <= 1'b1;
			mosi_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rx_q   <= 8'h00;
		end else begin
			done_q <= 1'b0;
			div_q  <= (st_q == SSS_M_IDLE || tick) ? 8'h00 : div_q + 8'h01;
			case (st_q)
				SSS_M_IDLE: begin
					sck_q <= cpol_i; // R2
					if (start_i) begin
						sr_q   <= tx_i;
						mosi_q <= tx_i[7];
						last_q <= last_i;
						tr_q   <= 5'h00;
						busy_q <= 1'b1;
						// falling select marks a fresh transmission
						st_q   <= ss_n_q ? SSS_M_SETUP : SSS_M_RUN; // R7
						ss_n_q <= 1'b0; // R7
					end
				end
				SSS_M_SETUP: begin
					if (tick) begin
						st_q <= SSS_M_RUN;
					end
				end
				SSS_M_RUN: begin
					if (tick) begin
						sck_q <= !sck_q;
						tr_q  <= tr_q + 5'h01;
						if (input_sample_phase) begin
							sr_q <= {sr_q[6:0], miso_s_q[1]};
						end else if (tr_q != 5'h00) begin
							mosi_q <= sr_q[7];
						end
						if (tr_q == 5'h0F) begin
							rx_q   <= input_sample_phase ? {sr_q[6:0], miso_s_q[1]} : sr_q;
							done_q <= 1'b1;
							st_q   <= last_q ? SSS_M_GAP : SSS_M_IDLE;
							busy_q <= last_q;
						end
					end
				end
				SSS_M_GAP: begin
					if (tick) begin
						ss_n_q <= 1'b1; // R7
						busy_q <= 1'b0;
						st_q   <= SSS_M_IDLE;
					end
				end
				default: begin
					st_q <= SSS_M_IDLE;
				end
			endcase
		end
	end

	assign busy_o    = busy_q;
	assign done_o    = done_q;
	assign rx_o      = rx_q;
	assign link.sck  = sck_q;
	assign link.ss_n = ss_n_q;
	assign link.mosi = mosi_q;
endmodule : sss_master

/* sss_link_asserts.sv */
// link assertions for the select-synchronised serial pair
`timescale 1ns/1ns
module sss_link_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	logic [3:0] since_q;
	logic [3:0] tgl_q;
	// cycles since the last clock or select edge
	always_ff @(posedge clk_i) begin
		if (rst_i || $changed(sck) || $changed(ss_n)) begin
			since_q <= 4'h0;
		end else if (since_q != 4'hF) begin
			since_q <= since_q + 4'h1;
		end
	end
	// clock toggles within one selected frame
	always_ff @(posedge clk_i) begin
		if (rst_i || ss_n) begin
			tgl_q <= 4'h0;
		end else if ($changed(sck)) begin
			tgl_q <= tgl_q + 4'h1;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_oe_idle: assert property (ss_n [*6] |-> !miso_oe)
		else $error("data output driven while deselected");
	chk_oe_release: assert property ($rose(ss_n) |-> ##[1:6] !miso_oe)
		else $error("data output not released after deselect");
	chk_oe_rose: assert property ($rose(miso_oe) |-> !ss_n)
		else $error("data output enabled without select");
	chk_oe_fell: assert property ($fell(miso_oe) |-> ss_n)
		else $error("data output dropped while selected");
	chk_miso_launch: assert property ($changed(miso) && miso_oe |-> since_q <= 4'h8)
		else $error("data output moved away from a clock edge");
	chk_byte_edges: assert property ($rose(ss_n) |-> tgl_q == 4'h0)
		else $error("frame not a whole number of bytes");
	chk_sck_hold: assert property ($rose(ss_n) |-> $stable(sck) ##1 $stable(sck))
		else $error("clock moved at deselect");
	chk_ss_first: assert property ($fell(ss_n) |-> $stable(sck))
		else $error("clock moved at select");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !miso_oe)
		else $error("data output driven after reset");
endmodule : sss_link_asserts

/* spi_slave_select_sync_bench.sv */
// self-checking bench joining master and slave ends of the serial link
`timescale 1ns/1ns
module spi_slave_select_sync_bench;
	import sss_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        irq;
	logic        sleep;
	logic        wake;
	logic        cpol;
	logic        cke;
	logic        start;
	logic        last;
	logic [7:0]  tx;
	logic        busy;
	logic        done;
	logic [7:0]  rx;
	logic [7:0]  s;
	logic [7:0]  m;
	logic [7:0]  p;
	int          fail_count;
	int          comparisons;
	logic [31:0] rd_q[$];
	logic [7:0]  rx_q[$];
	sss_link_if link ();
	sss_slave sss_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
		.sleep_i(sleep), .wake_o(wake), .link(link));
	sss_master sss_master_inst (.clk_i(clk_i), .rst_i(rst_i), .cpol_i(cpol), .cke_i(cke), .start_i(start),
		.last_i(last), .tx_i(tx), .busy_o(busy), .done_o(done), .rx_o(rx), .link(link));
	sss_link_asserts sss_link_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .sck(link.sck), .ss_n(link.ss_n),
		.mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	// one classic wishbone cycle, entered and left at a rising edge
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic rd(logic [7:0] a, logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask : rd
	// one byte from the master end, expectation noted when chk is set
	task automatic xfer(logic [7:0] t, logic [7:0] e, logic chk);
		if (chk) rx_q.push_back(e);
		tx <= t;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		repeat (2) @(posedge clk_i);
		while (busy !== 1'b0) @(posedge clk_i);
		repeat (8) @(posedge clk_i);
	endtask : xfer
	// disable, settle the idle clock level, then enable
	task automatic cfg(logic [8:0] c);
		wb(1'b1, SSS_CTRL_OFS, {23'h0, c & 9'h17F});
		cpol <= c[SSS_CTRL_CPOL];
		cke <= c[SSS_CTRL_CKE];
		repeat (4) @(posedge clk_i);
		wb(1'b1, SSS_CTRL_OFS, {23'h0, c});
	endtask : cfg
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
			check("read data", rdat, rd_q.pop_front());
		end
		if (done === 1'b1 && rx_q.size() > 0) begin
			check("master rx", {24'h0, rx}, {24'h0, rx_q.pop_front()});
		end
	end
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
	initial begin
		{cyc, we, start, sleep, cpol, cke} = 6'h00;
		adr = 8'h00;
		wdat = 32'h0;
		tx = 8'h00;
		last = 1'b1;
		rst_i = 1'b1;
		fail_count = 0;
		comparisons = 0;
		void'($urandom(60));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(SSS_CTRL_OFS, 32'h0);
		rd(8'h14, 32'h0);
		rd(SSS_IRQ_MASK_OFS, 32'h0);
		for (int k = 0; k < 2; k++) begin
			cfg({2'b01, 1'b0, k[0], k[0], SSS_MODE_SLAVE_SS});
			wb(1'b1, SSS_IRQ_STAT_OFS, 32'h7);
			rd(SSS_STATUS_OFS, {29'h0, 1'b1, k[0], 1'b0});
			s = $urandom;
			m = $urandom;
			wb(1'b1, SSS_DATA_OFS, {24'h0, s});
			xfer(m, s, 1'b1);
			rd(SSS_IRQ_STAT_OFS, 32'h1);
			rd(SSS_DATA_OFS, {24'h0, m});
			p = $urandom;
			xfer(p, m, 1'b1);
			rd(SSS_DATA_OFS, {24'h0, p});
			$display("test %0d done", k);
		end
		wb(1'b1, SSS_IRQ_STAT_OFS, 32'h7);
		m = $urandom;
		xfer(m, p, 1'b1);
		wb(1'b1, SSS_DATA_OFS, {24'h0, s});
		rd(SSS_IRQ_STAT_OFS, 32'h5);
		cfg({2'b11, 3'b000, SSS_MODE_SLAVE_SS});
		s = $urandom;
		p = $urandom;
		wb(1'b1, SSS_DATA_OFS, {24'h0, s});
		xfer(p, s, 1'b1);
		rd(SSS_DATA_OFS, {24'h0, p});
		rd(SSS_IRQ_STAT_OFS, 32'h5);
		$display("test 2 done");
		wb(1'b1, SSS_IRQ_STAT_OFS, 32'h7);
		wb(1'b1, SSS_IRQ_MASK_OFS, 32'h1);
		sleep <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("irq idle", {31'h0, irq}, 32'h0);
		xfer(8'h3C, p, 1'b1);
		check("irq", {31'h0, irq}, 32'h1);
		check("wake", {31'h0, wake}, 32'h1);
		wb(1'b1, SSS_IRQ_STAT_OFS, 32'h1);
		repeat (3) @(posedge clk_i);
		check("irq cleared", {31'h0, irq}, 32'h0);
		sleep <= 1'b0;
		$display("test 3 done");
		cfg({2'b01, 3'b000, 4'h0});
		xfer(8'hA5, 8'h00, 1'b0);
		rd(SSS_IRQ_STAT_OFS, 32'h0);
		$display("test 4 done");
		rd(SSS_DATA_OFS, {24'h0, 8'h3C});
		cfg({2'b01, 3'b000, SSS_MODE_SLAVE_SS});
		m = $urandom;
		last <= 1'b0;
		xfer(m, 8'h3C, 1'b1);
		last <= 1'b1;
		xfer(8'h5A, m, 1'b1);
		rd(SSS_DATA_OFS, {24'h0, m});
		rd(SSS_IRQ_STAT_OFS, 32'h3);
		$display("test 5 done");
		summarize();
	end
endmodule : spi_slave_select_sync_bench
